// file: src/aid_cfg.svh
`ifndef AID_CFG_SVH
`define AID_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AID_OFS_CTRL 12'h000
`define AID_OFS_STATUS 12'h004
`define AID_OFS_CMD 12'h008
`define AID_OFS_DATA 12'h00C
`define AID_OFS_GEOM 12'h010
`define AID_OFS_CAP 12'h014
`define AID_OFS_MAXLBA_LO 12'h018
`define AID_OFS_MAXLBA_HI 12'h01C
`define AID_OFS_UDMA 12'h020
`define AID_OFS_USER_SN 12'h040
`define AID_OFS_UNIQ_SN 12'h080
`define AID_OFS_FW 12'h0C0

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define AID_CMD_IDENTIFY 8'hEC
`define AID_STAT_DRQ 0
`define AID_STAT_BUSY 1
`define AID_STAT_DONE 2
`define AID_STAT_DRIVE 3
`define AID_CTRL_ABORT 0
`define AID_DRIVE_BIT 4
`define AID_W0 16'h044A
`define AID_W47 16'h8001
`define AID_W49 16'h0B00
`define AID_W51 16'h0200
`define AID_W53 16'h0007
`define AID_W59 16'h0100
`define AID_W63 16'h0007
`define AID_W64 16'h0003
`define AID_W65_68 16'h0078
`define AID_W80 16'h00FE
`define AID_W81 16'h0021
`define AID_W82 16'h706B
`define AID_W83 16'h7408
`define AID_W84 16'h4000
`define AID_W88_LO 8'h7F
`define AID_W91 16'h0000
`define AID_W217 16'h0001
`define AID_SIG 8'hA5
`define AID_PAD 8'h20
`define AID_ASCII_ZERO 8'h30
`define AID_CYC_NS 120

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AID_RST_CYL 16'h0400
`define AID_RST_HEADS 16'h0010
`define AID_RST_SPT 16'h003F
`define AID_RST_UDMA 8'h00
`endif

// file: src/aid_pkg.sv
package aid_pkg;
    typedef enum logic [1:0] {
        AID_IDLE,
        AID_SEND,
        AID_DONE
    } aid_state_t;

    typedef struct packed {
        logic [15:0] cyl;
        logic [15:0] heads;
        logic [15:0] spt;
    } aid_geom_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic [1:0] rresp;
    } aid_rd_t;
endpackage

// file: src/aid_identify.sv
`timescale 1ns/100ps
`include "aid_cfg.svh"
module aid_identify
    import aid_pkg::*;
#(
    parameter int WORDS = 256
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic data_request
);

    if (WORDS != 256) begin : g_words_check
        $error("Parameter block is 256 words");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    aid_state_t state, next_state;
    logic [7:0] idx, next_idx;
    logic [7:0] csum, next_csum;
    aid_geom_t geom, next_geom;
    logic [31:0] max_lba_lo, next_max_lba_lo, max_lba_hi, next_max_lba_hi;
    logic [7:0] udma_sel, next_udma_sel;
    logic drive, next_drive;
    logic [7:0] user_sn [10];
    logic [7:0] next_user_sn [10];
    logic [7:0] uniq_sn [10];
    logic [7:0] next_uniq_sn [10];
    logic [7:0] fw [8];
    logic [7:0] next_fw [8];
    logic awready, next_awready, wready, next_wready;
    logic bvalid, next_bvalid, arready, next_arready, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp;
    aid_rd_t rd, next_rd;
    logic [11:0] awaddr, next_awaddr;
    logic [31:0] wdata, next_wdata;
    logic [3:0] wstrb, next_wstrb;
    logic have_aw, next_have_aw, have_w, next_have_w;
    logic drq, next_drq;

    // Serial field byte: user half left, unique half right, 20H pad on 00H
    function automatic logic [7:0] sn_byte(input logic [7:0] b);
        sn_byte = (b == 8'h00) ? `AID_PAD : b;
    endfunction

    // ----------------------------------------
    // Parameter word lookup
    // ----------------------------------------
    function automatic logic [15:0] pword(input logic [7:0] w);
        logic [31:0] cap;
        int k;
        cap = 32'(geom.cyl) * 32'(geom.heads) * 32'(geom.spt);
        k = 0;
        pword = 16'h0000;
        if (w == 8'd0) pword = `AID_W0;
        else if (w == 8'd1 || w == 8'd54)
            pword = geom.cyl;
        else if (w == 8'd3 || w == 8'd55) pword = geom.heads;
        else if (w == 8'd6 || w == 8'd56) pword = geom.spt;
        else if (w >= 8'd10 && w <= 8'd14) begin
            k = 2 * (int'(w) - 10);
            pword = {sn_byte(user_sn[k]), sn_byte(user_sn[k + 1])};
        end else if (w >= 8'd15 && w <= 8'd19) begin
            k = 2 * (int'(w) - 15);
            pword = {sn_byte(uniq_sn[k]), sn_byte(uniq_sn[k + 1])};
        end else if (w >= 8'd23 && w <= 8'd26) begin
            k = 2 * (int'(w) - 23);
            pword = {fw[k], fw[k + 1]};
        end else if (w == 8'd47) pword = `AID_W47;
        else if (w == 8'd49) pword = `AID_W49;
        else if (w == 8'd51) pword = `AID_W51;
        else if (w == 8'd53) pword = `AID_W53;
        else if (w == 8'd57 || w == 8'd60) pword = cap[15:0];
        else if (w == 8'd58 || w == 8'd61) pword = cap[31:16];
        else if (w == 8'd59) pword = `AID_W59;
        else if (w == 8'd63) pword = `AID_W63;
        else if (w == 8'd64) pword = `AID_W64;
        else if (w >= 8'd65 && w <= 8'd68) pword = `AID_W65_68;
        else if (w == 8'd80) pword = `AID_W80;
        else if (w == 8'd81) pword = `AID_W81;
        else if (w == 8'd82) pword = `AID_W82;
        else if (w == 8'd83) pword = `AID_W83;
        else if (w == 8'd84) pword = `AID_W84;
        else if (w == 8'd88) pword = {udma_sel, `AID_W88_LO};
        else if (w == 8'd91) pword = `AID_W91;
        else if (w == 8'd100) pword = max_lba_lo[15:0];
        else if (w == 8'd101) pword = max_lba_lo[31:16];
        else if (w == 8'd102) pword = max_lba_hi[15:0];
        else if (w == 8'd103) pword = max_lba_hi[31:16];
        else if (w == 8'd217) pword = `AID_W217;
    endfunction

    logic [15:0] cur_word;
    logic [15:0] final_word;
    assign cur_word = pword(idx);
    // Two's complement of the running byte sum plus the signature, signature in low byte
    assign final_word = {8'(8'h00 - csum - `AID_SIG),
                         `AID_SIG};

    // ----------------------------------------
    // AXI4-Lite and command engine
    // ----------------------------------------
    logic wr_go, rd_go, data_pop;
    logic [15:0] out_word;
    always_comb begin
        next_state = state;
        next_idx = idx;
        next_csum = csum;
        next_geom = geom;
        next_max_lba_lo = max_lba_lo;
        next_max_lba_hi = max_lba_hi;
        next_udma_sel = udma_sel;
        next_drive = drive;
        next_user_sn = user_sn;
        next_uniq_sn = uniq_sn;
        next_fw = fw;
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rd = rd;
        next_awaddr = awaddr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_have_aw = have_aw;
        next_have_w = have_w;
        next_drq = drq;
        out_word = (idx == 8'hFF) ? final_word : cur_word;
        data_pop = 1'b0;
        if (s_axi_awvalid && awready) begin
            next_awaddr = s_axi_awaddr;
            next_have_aw = 1'b1;
            next_awready = 1'b0;
        end
        if (s_axi_wvalid && wready) begin
            next_wdata = s_axi_wdata;
            next_wstrb = s_axi_wstrb;
            next_have_w = 1'b1;
            next_wready = 1'b0;
        end
        wr_go = have_aw && have_w && !bvalid;
        if (wr_go) begin
            next_have_aw = 1'b0;
            next_have_w = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = 2'b00;
            if (awaddr == `AID_OFS_CMD) begin
                if (wstrb[0] && wdata[7:0] == `AID_CMD_IDENTIFY
                    && state != AID_SEND) begin
                    next_state = AID_SEND;
                    next_idx = 8'h00;
                    next_csum = 8'h00;
                    next_drq = 1'b1;
                end
                // Only the drive-select bit is kept from drive_head_reg
                if (wstrb[1]) next_drive = wdata[8 + `AID_DRIVE_BIT];
            end else if (awaddr == `AID_OFS_CTRL) begin
                if (wstrb[0] && wdata[`AID_CTRL_ABORT]) begin
                    next_state = AID_IDLE;
                    next_drq = 1'b0;
                end
            end else if (awaddr == `AID_OFS_GEOM) begin
                next_geom.cyl = wdata[15:0];
                next_geom.heads = {8'h00, wdata[23:16]};
                next_geom.spt = {8'h00, wdata[31:24]};
            end else if (awaddr == `AID_OFS_MAXLBA_LO) begin
                next_max_lba_lo = wdata;
            end else if (awaddr == `AID_OFS_MAXLBA_HI) begin
                next_max_lba_hi = {16'h0000, wdata[15:0]};
            end else if (awaddr == `AID_OFS_UDMA) begin
                next_udma_sel = wdata[7:0];
            end else if (awaddr >= `AID_OFS_USER_SN
                && awaddr < `AID_OFS_USER_SN + 12'd40) begin
                next_user_sn[4'((awaddr - `AID_OFS_USER_SN) >> 2)] = wdata[7:0];
            end else if (awaddr >= `AID_OFS_UNIQ_SN
                && awaddr < `AID_OFS_UNIQ_SN + 12'd40) begin
                next_uniq_sn[4'((awaddr - `AID_OFS_UNIQ_SN) >> 2)] = wdata[7:0];
            end else if (awaddr >= `AID_OFS_FW
                && awaddr < `AID_OFS_FW + 12'd32) begin
                next_fw[3'((awaddr - `AID_OFS_FW) >> 2)] = wdata[7:0];
            end else begin
                next_bresp = 2'b10;
            end
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        rd_go = s_axi_arvalid && arready;
        if (rd_go) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rd.rresp = 2'b00;
            next_rd.rdata = 32'h0000_0000;
            if (s_axi_araddr == `AID_OFS_STATUS) begin
                next_rd.rdata[`AID_STAT_DRQ] = drq;
                next_rd.rdata[`AID_STAT_BUSY] = (state == AID_SEND);
                next_rd.rdata[`AID_STAT_DONE] = (state == AID_DONE);
                next_rd.rdata[`AID_STAT_DRIVE] = drive;
                next_rd.rdata[15:8] = idx;
            end else if (s_axi_araddr == `AID_OFS_DATA) begin
                if (state == AID_SEND) begin
                    next_rd.rdata = {16'h0000, out_word};
                    data_pop = 1'b1;
                end
            end else if (s_axi_araddr == `AID_OFS_GEOM) begin
                next_rd.rdata = {geom.spt[7:0], geom.heads[7:0], geom.cyl};
            end else if (s_axi_araddr == `AID_OFS_MAXLBA_LO) begin
                next_rd.rdata = max_lba_lo;
            end else if (s_axi_araddr == `AID_OFS_MAXLBA_HI) begin
                next_rd.rdata = max_lba_hi;
            end else if (s_axi_araddr == `AID_OFS_UDMA) begin
                next_rd.rdata = {24'h000000, udma_sel};
            end else if (s_axi_araddr == `AID_OFS_CTRL
                || s_axi_araddr == `AID_OFS_CMD) begin
                next_rd.rdata = 32'h0000_0000;
            end else begin
                next_rd.rresp = 2'b10;
            end
        end
        if (data_pop) begin
            next_csum = 8'(csum + out_word[7:0] + out_word[15:8]);
            next_idx = 8'(idx + 8'd1);
            if (idx == 8'hFF) begin
                next_state = AID_DONE;
                next_drq = 1'b0;
            end
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= AID_IDLE;
            idx <= 8'h00;
            csum <= 8'h00;
            geom <= '{`AID_RST_CYL, `AID_RST_HEADS, `AID_RST_SPT};
            max_lba_lo <= 32'h0000_0000;
            max_lba_hi <= 32'h0000_0000;
            udma_sel <= `AID_RST_UDMA;
            drive <= 1'b0;
            for (int i = 0; i < 10; i++) begin
                user_sn[i] <= `AID_ASCII_ZERO;
                uniq_sn[i] <= `AID_ASCII_ZERO;
            end
            for (int i = 0; i < 8; i++) begin
                fw[i] <= `AID_ASCII_ZERO;
            end
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= 2'b00;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rd <= '0;
            awaddr <= 12'h000;
            wdata <= 32'h0000_0000;
            wstrb <= 4'h0;
            have_aw <= 1'b0;
            have_w <= 1'b0;
            drq <= 1'b0;
        end else begin
            state <= next_state;
            idx <= next_idx;
            csum <= next_csum;
            geom <= next_geom;
            max_lba_lo <= next_max_lba_lo;
            max_lba_hi <= next_max_lba_hi;
            udma_sel <= next_udma_sel;
            drive <= next_drive;
            user_sn <= next_user_sn;
            uniq_sn <= next_uniq_sn;
            fw <= next_fw;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rd <= next_rd;
            awaddr <= next_awaddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            have_aw <= next_have_aw;
            have_w <= next_have_w;
            drq <= next_drq;
        end
    end

    assign s_axi_awready = awready;
    assign s_axi_wready = wready;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_arready = arready;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rd.rdata;
    assign s_axi_rresp = rd.rresp;
    assign data_request = drq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_cmd_starts: assert property (wr_go && awaddr == `AID_OFS_CMD && wstrb[0]
        && wdata[7:0] == `AID_CMD_IDENTIFY && state == AID_IDLE
        |=> state == AID_SEND && drq && idx == 8'h00)
        else $error("Identify command did not start transfer");
    a_block_len: assert property (data_pop && idx == 8'hFF
        |=> state == AID_DONE && !drq)
        else $error("Transfer did not end after word 255");
    a_word_zero: assert property (data_pop && idx == 8'd0
        |=> s_axi_rdata[15:0] == 16'h044A)
        else $error("Word 0 wrong");
    a_word_47: assert property (data_pop && idx == 8'd47
        |=> s_axi_rdata[15:0] == 16'h8001)
        else $error("Word 47 wrong");
    a_word_49: assert property (data_pop && idx == 8'd49
        |=> s_axi_rdata[15:0] == 16'h0B00)
        else $error("Word 49 wrong");
    a_word_53: assert property (data_pop && idx == 8'd53
        |=> s_axi_rdata[15:0] == 16'h0007)
        else $error("Word 53 wrong");
    a_timing_words: assert property (data_pop && idx >= 8'd65 && idx <= 8'd68
        |=> s_axi_rdata[15:0] == 16'h0078)
        else $error("Cycle time word wrong");
    a_apm_zero: assert property (data_pop && idx == 8'd91
        |=> s_axi_rdata[15:0] == 16'h0000)
        else $error("Word 91 not zero");
    a_reserved: assert property (data_pop && idx == 8'd2
        |=> s_axi_rdata[15:0] == 16'h0000)
        else $error("Reserved word not zero");
    a_checksum: assert property (data_pop && idx == 8'hFF
        |=> 8'(s_axi_rdata[15:8] + $past(csum) + 8'hA5) == 8'h00
        && s_axi_rdata[7:0] == 8'hA5)
        else $error("Integrity word wrong");

    c_identify: cover property (state == AID_IDLE ##1 state == AID_SEND);
    c_done: cover property (state == AID_SEND ##1 state == AID_DONE);
    c_abort: cover property (state == AID_SEND ##1 state == AID_IDLE);
endmodule

// file: sim/aid_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host side of the register bus
// ----------------------------------------
module aid_host (
    input wire logic aclk,
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    output logic tout
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready, tout} = '0;
    end

    // Command and task-file writes
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 1'b0;
        r = 2'b11;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done && n < 200) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done)
            tout <= 1'b1;
    endtask

    // One data word per read request
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 1'b0;
        r = 2'b11;
        d = 32'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done && n < 200) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done)
            tout <= 1'b1;
    endtask
endmodule

// file: sim/tb_ata_identify_responder.sv
`timescale 1ns/100ps
`include "aid_cfg.svh"
module tb_ata_identify_responder
    import aid_pkg::*;
;
    logic aclk, aresetn, data_request, tout;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_count, n_tests;
    logic [15:0] cyl, hd, spt;
    logic [47:0] lba;
    logic [7:0] ud;
    logic [7:0] fw [8];
    logic [7:0] sn [20];
    logic [15:0] blk [256];

    aid_identify #(.WORDS(256)) aid_identify_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .data_request
    );

    aid_host aid_host_inst (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .tout
    );

    // ----------------------------------------
    // Clock, report and helpers
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic results();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge aclk) begin
        if (tout === 1'b1) begin
            err_count++;
            results();
        end
    end

    task automatic eq(input int id, input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: item %0d got %h want %h",
                     $time, id, g, e);
        end
    endtask

    task automatic chk(input int i, input logic [15:0] e);
        eq(i, {16'h0, blk[i]}, {16'h0, e});
    endtask

    task automatic w(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        aid_host_inst.wr(a, d, r);
        eq(1000, {30'h0, r}, 32'h0);
    endtask

    function automatic logic [15:0] pr(input logic [7:0] a, b);
        return {(a == 8'h00) ? `AID_PAD : a, (b == 8'h00) ? `AID_PAD : b};
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_idle();
        logic [31:0] d;
        logic [1:0] r;
        @(negedge aclk);
        eq(1, {31'h0, data_request}, 32'h0);
        aid_host_inst.rd(`AID_OFS_DATA, d, r);
        eq(2, d, 32'h0);
        aid_host_inst.rd(12'hFFC, d, r);
        eq(3, {30'h0, r}, 32'h2);
        w(`AID_OFS_CMD, 32'h0000_0020);
        @(negedge aclk);
        eq(4, {31'h0, data_request}, 32'h0);
        w(`AID_OFS_CMD, 32'h0000_00EC);
        aid_host_inst.rd(`AID_OFS_DATA, d, r);
        eq(8, d, {16'h0, `AID_W0});
        w(`AID_OFS_CTRL, 32'h0000_0001);
        @(negedge aclk);
        eq(9, {31'h0, data_request}, 32'h0);
    endtask

    task automatic check_block();
        logic [31:0] cap;
        logic [7:0] s;
        cap = 32'(cyl) * 32'(hd) * 32'(spt);
        s = `AID_SIG;
        for (int i = 0; i < 255; i++)
            s = s + blk[i][15:8] + blk[i][7:0];
        chk(0, `AID_W0);
        chk(1, cyl);
        chk(3, hd);
        chk(6, spt);
        for (int k = 0; k < 5; k++) begin
            chk(10 + k, pr(sn[2*k], sn[2*k+1]));
            chk(15 + k, pr(sn[10+2*k], sn[11+2*k]));
        end
        for (int k = 0; k < 4; k++)
            chk(23 + k, {fw[2*k], fw[2*k+1]});
        chk(47, `AID_W47);
        chk(49, `AID_W49);
        chk(51, `AID_W51);
        chk(64, `AID_W64);
        chk(53, `AID_W53);
        chk(54, cyl);
        chk(55, hd);
        chk(56, spt);
        chk(57, cap[15:0]);
        chk(58, cap[31:16]);
        for (int i = 65; i < 69; i++)
            chk(i, `AID_W65_68);
        chk(80, `AID_W80);
        chk(81, `AID_W81);
        chk(82, `AID_W82);
        chk(83, `AID_W83);
        chk(84, `AID_W84);
        chk(88, {ud, `AID_W88_LO});
        chk(91, `AID_W91);
        chk(100, lba[15:0]);
        chk(101, lba[31:16]);
        chk(102, lba[47:32]);
        chk(103, 16'h0000);
        chk(217, `AID_W217);
        chk(255, {8'h00 - s, `AID_SIG});
        for (int i = 0; i < 255; i++)
            if (i inside {2, 4, 5, 20, 48, 50, 52, 62, [69:79], 92,
                          [104:127], [129:216], [218:254]})
                chk(i, 16'h0000);
    endtask

    task automatic t_run(input bit prog);
        logic [31:0] d;
        logic [1:0] r;
        logic [11:0] a;
        lba = prog ? 48'h0009_1234_5678 : 48'h0000_00F0_0000;
        if (prog) begin
            cyl = 16'h0F00;
            hd = 16'h0008;
            spt = 16'h0020;
            ud = 8'h04;
            w(`AID_OFS_GEOM, {spt[7:0], hd[7:0], cyl});
            w(`AID_OFS_UDMA, {24'h0, ud});
        end
        w(`AID_OFS_MAXLBA_LO, lba[31:0]);
        w(`AID_OFS_MAXLBA_HI, {16'h0, lba[47:32]});
        for (int i = 0; i < 20; i++) begin
            if (i < 10)
                sn[i] = prog ? 8'(8'h41 + i) : `AID_ASCII_ZERO;
            else
                sn[i] = (i == 10) ? 8'h00 : 8'(8'h4B + i);
            a = (i < 10) ? `AID_OFS_USER_SN + 12'(4 * i)
                         : `AID_OFS_UNIQ_SN + 12'(4 * (i - 10));
            if (prog || i >= 10)
                w(a, {24'h0, sn[i]});
        end
        for (int i = 0; i < 8; i++) begin
            fw[i] = prog ? 8'(8'h61 + i) : `AID_ASCII_ZERO;
            if (prog)
                w(`AID_OFS_FW + 12'(4 * i), {24'h0, fw[i]});
        end
        w(`AID_OFS_CMD, 32'h0000_1FEC);
        @(negedge aclk);
        eq(5, {31'h0, data_request}, 32'h1);
        aid_host_inst.rd(`AID_OFS_STATUS, d, r);
        eq(6, {31'h0, d[`AID_STAT_DRQ]}, 32'h1);
        eq(10, {31'h0, d[`AID_STAT_DRIVE]}, 32'h1);
        for (int i = 0; i < 256; i++) begin
            aid_host_inst.rd(`AID_OFS_DATA, d, r);
            blk[i] = d[15:0];
            if (i == 9)
                w(`AID_OFS_CMD, 32'h0000_00EC);
        end
        @(negedge aclk);
        eq(7, {31'h0, data_request}, 32'h0);
        aid_host_inst.rd(`AID_OFS_STATUS, d, r);
        eq(11, {31'h0, d[`AID_STAT_DONE]}, 32'h1);
        check_block();
    endtask

    initial begin
        aresetn = 1'b0;
        err_count = 0;
        n_tests = 0;
        cyl = `AID_RST_CYL;
        hd = `AID_RST_HEADS;
        spt = `AID_RST_SPT;
        ud = `AID_RST_UDMA;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_idle();
        t_run(1'b0);
        t_run(1'b1);
        results();
    end
endmodule
